// ===== verif/adc_conv_timing_tb_top.sv
// Testbench: drives the converter timing control and judges timing, results and flags.
// Assumes one 20 MHz clock and a simple sample-and-hold comparator modelled here.
`timescale 1ns/10ps
module adc_conv_timing_tb_top;
	import adc_timing_pkg::*;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	converter_control_word_t conv_ctrl = '0;
	logic start_conv = 1'b0;
	logic result_read = 1'b0;
	logic cmp_above = 1'b0;
	logic below_low_ref = 1'b0;
	logic above_high_ref = 1'b0;
	logic sample_en;
	logic [RESULT_BITS-1:0] dac_code;
	logic [RESULT_BITS-1:0] result;
	conv_status_t status;
	logic [9:0] analog_in = 10'h000;
	logic [9:0] held_level = 10'h000;
	int bad_count = 0;
	int check_count = 0;

	adc_conv_timing dut (.sys_clk(sys_clk), .reset_n(reset_n), .conv_ctrl(conv_ctrl),
		.start_conv(start_conv), .result_read(result_read), .cmp_above(cmp_above),
		.below_low_ref(below_low_ref), .above_high_ref(above_high_ref),
		.sample_en(sample_en), .dac_code(dac_code), .result(result), .status(status));

	// Clock
	always #25 sys_clk = ~sys_clk;

	// Hold capacitor tracks the input only while the switch is closed
	always @(posedge sys_clk) begin
		#1;
		if (sample_en === 1'b1) held_level = analog_in;
		cmp_above = (held_level >= dac_code);
	end

	// Compare and count
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	// Verdict and end of run
	task automatic conclude();
		if (bad_count == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// All outputs quiet
	task automatic check_idle();
		check(status, 3'h0);
		check(sample_en, 1'b0);
		check(result, 10'h000);
		check(dac_code, 10'h000);
	endtask

	// One conversion: count busy and window cycles, then check result and read clear
	task automatic run_conv(input logic [1:0] ccs, input logic [1:0] scs,
		input logic [9:0] lvl, input logic lo, input logic hi, input logic [9:0] exp_res,
		input logic poke);
		int t;
		int s;
		int n;
		int busy_cnt;
		int win_cnt;
		int odd;
		int i;
		logic fell;
		t = (ccs == CCS_96) ? TCC_PHASES_CODE10 : (ccs == CCS_48) ? TCC_PHASES_CODE11
			: TCC_PHASES_CODE00;
		s = t << scs;
		n = CONV_STEPS * t + SAMPLE_TSC_COUNT * s + LOAD_PHASES;
		conv_ctrl = '{conv_clock_select: ccs, sample_clock_select: scs, other_bits: 12'h000};
		analog_in = lvl;
		below_low_ref = lo;
		above_high_ref = hi;
		start_conv = 1'b1;
		@(posedge sys_clk);
		#1;
		start_conv = 1'b0;
		busy_cnt = 0;
		win_cnt = 0;
		odd = 0;
		fell = 1'b0;
		for (i = 0; i < 4000; i++) begin
			if (status.busy !== 1'b1) break;
			busy_cnt++;
			if (sample_en === 1'b1) begin
				win_cnt++;
				if (fell || dac_code !== RESULT_MSB) odd++;
			end else begin
				fell = 1'b1;
				analog_in = ~lvl;
			end
			if (status.sampling !== sample_en || status.conv_done !== 1'b0) odd++;
			start_conv = poke && (i == 5);
			if (poke && i == 5) conv_ctrl = 16'hF000;
			@(posedge sys_clk);
			#1;
		end
		below_low_ref = 1'b0;
		above_high_ref = 1'b0;
		check(busy_cnt, n);
		check(win_cnt, 2 * s);
		check(odd, 0);
		check(result, exp_res);
		check(status.conv_done, 1'b1);
		check(sample_en, 1'b0);
		result_read = 1'b1;
		@(posedge sys_clk);
		#1;
		result_read = 1'b0;
		check(status.conv_done, 1'b0);
		check(result, exp_res);
	endtask

	// Reset in the middle of a conversion clears everything
	task automatic reset_mid();
		conv_ctrl = '{conv_clock_select: CCS_48, sample_clock_select: 2'h0, other_bits: 12'h000};
		start_conv = 1'b1;
		@(posedge sys_clk);
		#1;
		start_conv = 1'b0;
		repeat (30) @(posedge sys_clk);
		#1;
		check(status.busy, 1'b1);
		reset_n = 1'b0;
		repeat (3) @(posedge sys_clk);
		#1;
		check_idle();
		reset_n = 1'b1;
	endtask

	// Main sequence; the reserved select code 01 is never programmed
	initial begin
		repeat (3) @(posedge sys_clk);
		#1;
		check_idle();
		reset_n = 1'b1;
		run_conv(CCS_24, 2'h0, 10'h2A5, 1'b0, 1'b0, 10'h2A5, 1'b0);
		run_conv(CCS_96, 2'h3, 10'h0F1, 1'b0, 1'b0, 10'h0F1, 1'b1);
		run_conv(CCS_48, 2'h1, 10'h3FE, 1'b0, 1'b0, 10'h3FE, 1'b0);
		run_conv(CCS_24, 2'h2, 10'h001, 1'b0, 1'b0, 10'h001, 1'b0);
		run_conv(CCS_48, 2'h0, 10'h155, 1'b1, 1'b0, RESULT_ZERO, 1'b0);
		run_conv(CCS_24, 2'h1, 10'h155, 1'b0, 1'b1, RESULT_FULL, 1'b0);
		run_conv(CCS_24, 2'h0, 10'h2AA, 1'b1, 1'b1, RESULT_ZERO, 1'b0);
		reset_mid();
		run_conv(CCS_96, 2'h0, 10'h3FF, 1'b0, 1'b0, 10'h3FF, 1'b0);
		conclude();
	end

	// Watchdog
	initial begin
		repeat (40000) @(posedge sys_clk);
		bad_count++;
		conclude();
	end
endmodule

// ===== verilog/adc_conv_timing.sv
// Converter timing control: sample window, fourteen conversion steps, result load.
// Assumes comparator and reference-range pins are asynchronous; control word is static.
//
// Overview of operation
// - Conversion clock select 00, 10, 11 gives 24, 96, 48 phases.
// - Sample clock select gives 1, 2, 4 or 8 conversion clock periods.
// - Sampling window lasts exactly two sample clock periods.
// - After the window closes the input is isolated from the result.
// - Total time is 14 conversion clocks plus window plus 4 phases.
// - Sequence is sampling, bit decisions, then result load, in order.
// - Result saturates to 000 below low reference, 3FF above high.
// - Durations come only from programmed fields and the CPU clock.
// - One CPU clock phase is one system clock cycle here.
`timescale 1ns/10ps
module adc_conv_timing
	import adc_timing_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire converter_control_word_t conv_ctrl,
	input wire logic start_conv,
	input wire logic result_read,
	input wire logic cmp_above,
	input wire logic below_low_ref,
	input wire logic above_high_ref,
	output logic sample_en,
	output logic [RESULT_BITS-1:0] dac_code,
	output logic [RESULT_BITS-1:0] result,
	output conv_status_t status
);
	typedef enum {ST_IDLE, ST_SAMPLE, ST_CONVERT, ST_LOAD} conv_state_t;

	localparam int TCC_PHASES_CODE96 = TCC_PHASES_CODE10;
	localparam int TCC_PHASES_CODE48 = TCC_PHASES_CODE11;

	// Conversion clock period in cycles for a select code
	function automatic logic [TIMER_WIDTH-1:0] tcc_of(input logic [1:0] sel);
		logic [TIMER_WIDTH-1:0] n;
		unique case (sel)
			CCS_96: n = TIMER_WIDTH'(TCC_PHASES_CODE96 * CYCLES_PER_PHASE);
			CCS_48: n = TIMER_WIDTH'(TCC_PHASES_CODE48 * CYCLES_PER_PHASE);
			// Reserved code 01 is never programmed; it falls back to 24
			CCS_24, CCS_RESERVED: n = TIMER_WIDTH'(TCC_PHASES_CODE00 * CYCLES_PER_PHASE);
		endcase
		return n;
	endfunction

	logic [SYNC_PINS-1:0] pin_raw;
	logic [SYNC_PINS-1:0] sync1_reg;
	logic [SYNC_PINS-1:0] sync2_reg;
	logic cmp_s;
	logic under_s;
	logic over_s;

	assign pin_raw = {above_high_ref, below_low_ref, cmp_above};

	// Two-stage synchronisers for the analog-side pins
	genvar gi;
	generate
		for (gi = 0; gi < SYNC_PINS; gi++) begin : g_sync
			always_ff @(posedge sys_clk) begin
				if (!reset_n) begin
					sync1_reg[gi] <= 1'b0;
					sync2_reg[gi] <= 1'b0;
				end else begin
					sync1_reg[gi] <= pin_raw[gi];
					sync2_reg[gi] <= sync1_reg[gi];
				end
			end
		end
	endgenerate

	assign cmp_s = sync2_reg[0];
	assign under_s = sync2_reg[1];
	assign over_s = sync2_reg[2];

	conv_state_t state_reg, state_next;
	logic [TIMER_WIDTH-1:0] tcc_reg, tcc_next;
	logic [TIMER_WIDTH-1:0] tsc_reg, tsc_next;
	logic [3:0] step_reg, step_next;
	logic [RESULT_BITS-1:0] code_reg, code_next;
	logic [RESULT_BITS-1:0] mask_reg, mask_next;
	logic [RESULT_BITS-1:0] dac_reg, dac_next;
	logic [RESULT_BITS-1:0] result_reg, result_next;
	logic under_reg, under_next;
	logic over_reg, over_next;
	logic sample_reg, sample_next;
	logic busy_reg, busy_next;
	logic done_reg, done_next;
	logic tmr_start;
	logic [TIMER_WIDTH-1:0] tmr_len;
	logic tmr_expire;
	logic [RESULT_BITS-1:0] decided;

	phase_timer u_timer (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.start(tmr_start),
		.length(tmr_len),
		.expire(tmr_expire)
	);

	// Sequencer next state
	always_comb begin
		state_next = state_reg;
		tcc_next = tcc_reg;
		tsc_next = tsc_reg;
		step_next = step_reg;
		code_next = code_reg;
		mask_next = mask_reg;
		dac_next = dac_reg;
		result_next = result_reg;
		under_next = under_reg;
		over_next = over_reg;
		sample_next = sample_reg;
		busy_next = busy_reg;
		done_next = done_reg;
		tmr_start = 1'b0;
		tmr_len = tcc_reg;
		decided = cmp_s ? (code_reg | mask_reg) : code_reg;
		// Read clears the flag; a load in the same cycle wins below
		if (result_read) begin
			done_next = 1'b0;
		end
		unique case (state_reg)
			ST_IDLE: begin
				if (start_conv) begin
					// Periods latched from the fields only
					tcc_next = tcc_of(conv_ctrl.conv_clock_select);
					tsc_next = tcc_next << conv_ctrl.sample_clock_select;
					tmr_start = 1'b1;
					tmr_len = TIMER_WIDTH'(SAMPLE_TSC_COUNT) * tsc_next;
					state_next = ST_SAMPLE;
					sample_next = 1'b1;
					busy_next = 1'b1;
					step_next = '0;
					code_next = '0;
					mask_next = RESULT_MSB;
					dac_next = RESULT_MSB;
				end
			end
			ST_SAMPLE: begin
				if (tmr_expire) begin
					// Close the window and hold; later input moves are ignored
					sample_next = 1'b0;
					under_next = under_s;
					over_next = over_s;
					state_next = ST_CONVERT;
					tmr_start = 1'b1;
				end
			end
			ST_CONVERT: begin
				if (tmr_expire) begin
					// One bit per step, MSB first, then idle steps
					if (mask_reg != '0) begin
						code_next = decided;
						mask_next = mask_reg >> 1;
						dac_next = decided | (mask_reg >> 1);
					end
					tmr_start = 1'b1;
					if (step_reg == LAST_STEP) begin
						tmr_len = LOAD_CYCLES;
						state_next = ST_LOAD;
					end else begin
						step_next = step_reg + 4'h1;
					end
				end
			end
			ST_LOAD: begin
				if (tmr_expire) begin
					// Out-of-range input saturates the code
					if (under_reg) begin
						result_next = RESULT_ZERO;
					end else if (over_reg) begin
						result_next = RESULT_FULL;
					end else begin
						result_next = code_reg;
					end
					done_next = 1'b1;
					busy_next = 1'b0;
					dac_next = '0;
					state_next = ST_IDLE;
				end
			end
		endcase
	end

	// Sequencer registers
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			state_reg <= ST_IDLE;
			tcc_reg <= '0;
			tsc_reg <= '0;
			step_reg <= '0;
			code_reg <= '0;
			mask_reg <= '0;
			dac_reg <= '0;
			result_reg <= '0;
			under_reg <= 1'b0;
			over_reg <= 1'b0;
			sample_reg <= 1'b0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			tcc_reg <= tcc_next;
			tsc_reg <= tsc_next;
			step_reg <= step_next;
			code_reg <= code_next;
			mask_reg <= mask_next;
			dac_reg <= dac_next;
			result_reg <= result_next;
			under_reg <= under_next;
			over_reg <= over_next;
			sample_reg <= sample_next;
			busy_reg <= busy_next;
			done_reg <= done_next;
		end
	end

	// Outputs straight from flops
	assign sample_en = sample_reg;
	assign dac_code = dac_reg;
	assign result = result_reg;
	assign status = '{busy: busy_reg, sampling: sample_reg, conv_done: done_reg};

	// Assertion helpers: cycle counts of the window and of the whole conversion
	logic [TIMER_WIDTH-1:0] samp_cnt_reg;
	logic [TIMER_WIDTH-1:0] total_cnt_reg;
	logic start_acc;
	assign start_acc = (state_reg == ST_IDLE) && start_conv;

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			samp_cnt_reg <= '0;
			total_cnt_reg <= '0;
		end else begin
			samp_cnt_reg <= sample_reg ? samp_cnt_reg + TIMER_WIDTH'(1) : '0;
			total_cnt_reg <= busy_reg ? total_cnt_reg + TIMER_WIDTH'(1) : '0;
		end
	end

	sequence seq_accept;
		start_acc;
	endsequence

	sequence seq_window_open;
		sample_reg [*8];
	endsequence

	AST_TCC_DECODE: assert property (@(posedge sys_clk) disable iff (!reset_n)
		start_acc |=> tcc_reg == (($past(conv_ctrl.conv_clock_select) == CCS_96) ? 12'h060 :
			($past(conv_ctrl.conv_clock_select) == CCS_48) ? 12'h030 : 12'h018)) else
		$error("conversion clock period does not match select code");

	AST_TSC_SCALE: assert property (@(posedge sys_clk) disable iff (!reset_n)
		start_acc |=> tsc_reg == (tcc_reg << $past(conv_ctrl.sample_clock_select))) else
		$error("sample clock period does not follow the sample select code");

	AST_WINDOW_LEN: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$fell(sample_reg) |-> $past(samp_cnt_reg) == (tsc_reg << 1) - 12'h001) else
		$error("sampling window length is wrong");

	AST_HOLD_AFTER: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$fell(sample_reg) |-> !sample_reg [*8]) else
		$error("sampling switch reopened during conversion");

	AST_TOTAL_TIME: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$fell(busy_reg) |-> $past(total_cnt_reg) ==
			12'(14 * tcc_reg + 2 * tsc_reg + 4) - 12'h001) else
		$error("total conversion time is wrong");

	AST_ORDER: assert property (@(posedge sys_clk) disable iff (!reset_n)
		seq_accept |=> seq_window_open ##1 (state_reg == ST_SAMPLE || state_reg == ST_CONVERT)) else
		$error("conversion did not begin with the sampling window");

	AST_SAT_LOW: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(state_reg == ST_LOAD && tmr_expire && under_reg) |=> result_reg == RESULT_ZERO) else
		$error("under-range input did not saturate to zero");

	AST_SAT_HIGH: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(state_reg == ST_LOAD && tmr_expire && !under_reg && over_reg)
			|=> result_reg == RESULT_FULL) else
		$error("over-range input did not saturate to full scale");

	AST_FIELDS_HELD: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(busy_reg && busy_next) |=> $stable(tcc_reg) && $stable(tsc_reg)) else
		$error("timing changed in the middle of a conversion");

	AST_DONE_SET: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$fell(busy_reg) |-> done_reg && ($past(state_reg) == ST_LOAD)) else
		$error("done flag not raised with the result load");

	AST_DONE_CLEAR: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(result_read && !(state_reg == ST_LOAD && tmr_expire)) |=> !done_reg) else
		$error("done flag not cleared by result read");
endmodule

// ===== verilog/adc_timing_pkg.sv
// Package: constants, field layout and carrier types for the converter timing control.
// Assumes one system clock whose single cycle stands for one CPU clock phase.
package adc_timing_pkg;
	// Clock and phase timing
	localparam int SYS_CLK_PERIOD_NS = 50;
	localparam int CPU_CLOCK_PHASE_NS = 50;
	localparam int CYCLES_PER_PHASE = (CPU_CLOCK_PHASE_NS + SYS_CLK_PERIOD_NS - 1)
		/ SYS_CLK_PERIOD_NS;
	// Conversion clock period in CPU clock phases per select code
	localparam int TCC_PHASES_CODE00 = 24;
	localparam int TCC_PHASES_CODE10 = 96;
	localparam int TCC_PHASES_CODE11 = 48;
	// Sequence lengths
	localparam int SAMPLE_TSC_COUNT = 2;
	localparam int CONV_STEPS = 14;
	localparam int LOAD_PHASES = 4;
	localparam int TIMER_WIDTH = 12;
	localparam logic [TIMER_WIDTH-1:0] LOAD_CYCLES = TIMER_WIDTH'(LOAD_PHASES * CYCLES_PER_PHASE);
	localparam logic [3:0] LAST_STEP = 4'(CONV_STEPS - 1);
	// Select codes and field positions in the control word
	localparam logic [1:0] CCS_24 = 2'h0;
	localparam logic [1:0] CCS_RESERVED = 2'h1;
	localparam logic [1:0] CCS_96 = 2'h2;
	localparam logic [1:0] CCS_48 = 2'h3;
	localparam int CCS_LSB = 14;
	localparam int SCS_LSB = 12;
	// Result coding
	localparam int RESULT_BITS = 10;
	localparam logic [RESULT_BITS-1:0] RESULT_ZERO = 10'h000;
	localparam logic [RESULT_BITS-1:0] RESULT_FULL = 10'h3FF;
	localparam logic [RESULT_BITS-1:0] RESULT_MSB = 10'h200;
	// Pin synchroniser
	localparam int SYNC_PINS = 3;

	// Converter control word as software programs it
	typedef struct packed {
		logic [1:0] conv_clock_select;
		logic [1:0] sample_clock_select;
		logic [11:0] other_bits;
	} converter_control_word_t;

	// Status outputs
	typedef struct packed {
		logic busy;
		logic sampling;
		logic conv_done;
	} conv_status_t;
endpackage

// ===== verilog/phase_timer.sv
// Phase timer: counts a loaded number of CPU clock phases and pulses at the end.
// Assumes a same-clock start pulse; a start in the expiry cycle restarts cleanly.
`timescale 1ns/10ps
module phase_timer
	import adc_timing_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic start,
	input wire logic [TIMER_WIDTH-1:0] length,
	output logic expire
);
	logic [TIMER_WIDTH-1:0] cnt_reg;
	logic [TIMER_WIDTH-1:0] cnt_next;
	logic run_reg;
	logic run_next;

	// Expire in the length-th cycle after start, one cycle per phase
	assign expire = run_reg && (cnt_reg == '0);

	// Down count with start priority
	always_comb begin
		cnt_next = cnt_reg;
		run_next = run_reg;
		if (start) begin
			cnt_next = length - TIMER_WIDTH'(1);
			run_next = 1'b1;
		end else if (run_reg) begin
			if (cnt_reg == '0) begin
				run_next = 1'b0;
			end else begin
				cnt_next = cnt_reg - TIMER_WIDTH'(1);
			end
		end
	end

	// Registers
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			cnt_reg <= '0;
			run_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			run_reg <= run_next;
		end
	end
endmodule
